// File: common/panel_rx_pkg.sv
package panel_rx_pkg;

  // link shape
  localparam int LANES = 4;
  localparam int BITS_PER_LANE = 7;
  localparam int WORD_W = LANES * BITS_PER_LANE;
  localparam int PERIOD_W = 8;

  // system clock
  localparam int CLK_HZ = 40_000_000;

  // longest lock interval, rounded down to whole cycles
  localparam int LOCK_TIME_MS = 10;
  localparam int LOCK_CYCLES = (LOCK_TIME_MS * (CLK_HZ / 1000) > 1) ?
                               LOCK_TIME_MS * (CLK_HZ / 1000) : 1;

  // period limits in system cycles; seven distinct strobes need seven cycles
  localparam int MIN_PERIOD_CYC = 7;
  localparam int MAX_PERIOD_CYC = 255;
  localparam int STABLE_PERIODS = 4;

  // suggested placement of fields in the parallel word
  localparam int RED_LSB = 0;
  localparam int GREEN_LSB = 8;
  localparam int BLUE_LSB = 16;
  localparam int LINE_SYNC_BIT = 24;
  localparam int FRAME_SYNC_BIT = 25;
  localparam int PIXEL_VALID_BIT = 26;
  localparam int SPARE_CTRL_BIT = 27;
  localparam int COLOUR_W = 8;

  // reset values
  localparam logic [WORD_W-1:0] WORD_RESET = 28'h0000000;
  localparam logic [PERIOD_W-1:0] PERIOD_RESET = 8'h00;

  typedef enum logic [1:0] {
    ST_SEARCH = 2'b00,
    ST_TRACK = 2'b01,
    ST_LOCKED = 2'b10
  } lock_state_t;

  // cycle within the link period at which bit k is sampled: centre of slot k
  function automatic logic [PERIOD_W-1:0] strobe_cycle(input int k,
                                                       input logic [PERIOD_W-1:0] period);
    logic [15:0] prod;
    prod = 16'((2 * k + 1)) * 16'(period);
    strobe_cycle = PERIOD_W'(prod / 16'(2 * BITS_PER_LANE));
  endfunction

endpackage

// File: hw/word_fifo.sv
module word_fifo #(
  parameter int WIDTH = 28,
  parameter int DEPTH = 4
) (
  // clock and clear
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_flush,
  // fill side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  // drain side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  // honest flags straight from the occupancy count
  assign o_in_ready = (count_reg != (AW + 1)'(DEPTH));
  assign o_out_valid = (count_reg != '0);
  assign o_out_data = mem[rd_ptr_reg];
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // storage needs no reset: nothing is read until counted in
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= i_in_data;
    end
  end

  // pointers and count
  always_ff @(posedge i_clk) begin
    if (i_reset | i_flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= bump(wr_ptr_reg);
      end
      if (pop) begin
        rd_ptr_reg <= bump(rd_ptr_reg);
      end
      if (push & ~pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop & ~push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule // word_fifo

// File: hw/lane_sampler.sv
module lane_sampler
  import panel_rx_pkg::*;
(
  // clock and clear
  input wire logic i_clk,
  input wire logic i_clear,
  // timing from the period tracker
  input wire logic i_edge,
  input wire logic [PERIOD_W-1:0] i_phase,
  input wire logic [PERIOD_W-1:0] i_period,
  input wire logic i_armed,
  // synchronised lanes
  input wire logic [LANES-1:0] i_lanes,
  // assembled word
  output logic [WORD_W-1:0] o_word,
  output logic o_word_valid
);
  logic [WORD_W-1:0] word_reg;
  logic [BITS_PER_LANE-1:0] got_reg;
  logic valid_reg;
  logic [BITS_PER_LANE-1:0] hit;

  assign o_word = word_reg;
  assign o_word_valid = valid_reg;

  // one hit per strobe position, all timed from the same link clock edge
  always_comb begin
    for (int k = 0; k < BITS_PER_LANE; k++) begin
      hit[k] = (i_phase == strobe_cycle(k, i_period));
    end
  end

  // capture each lane at its slot; word index is lane*7 + bit
  // below 14 cycles per period bit 0 sits on the edge cycle, so the mask clear and its first mark share
  // one edge; the later assignment wins and keeps the mark
  always_ff @(posedge i_clk) begin
    if (i_clear) begin
      word_reg <= WORD_RESET;
      got_reg <= '0;
    end else begin
      if (i_edge) begin
        got_reg <= '0;
      end
      for (int k = 0; k < BITS_PER_LANE; k++) begin
        if (hit[k] & i_armed) begin
          got_reg[k] <= 1'b1;
          for (int l = 0; l < LANES; l++) begin
            word_reg[l * BITS_PER_LANE + k] <= i_lanes[l];
          end
        end
      end
    end
  end

  // a word counts only when every earlier slot of this period was seen
  always_ff @(posedge i_clk) begin
    if (i_clear) begin
      valid_reg <= 1'b0;
    end else begin
      valid_reg <= hit[BITS_PER_LANE-1] & i_armed & ~i_edge &
                   (&got_reg[BITS_PER_LANE-2:0]);
    end
  end
endmodule // lane_sampler

// File: hw/serial_to_parallel_panel_receiver.sv
// Overview of operation
// - four data lanes and one clock lane; clock lane times every data lane
// - 28 output bits: 8 red, 8 green, 8 blue, line/frame sync, valid, spare
// - seven strobe points per lane, bit 0 to bit 6, each link period
// - output strobe falling edge marks stable data; downstream samples there
// - sleep_n low forces all parallel outputs low
// - power-down with outputs low completes within 1 microsecond
// - lock to link clock within 10 ms; no valid output before lock
// - output strobe period follows link clock; sender keeps period in range
module serial_to_parallel_panel_receiver
  import panel_rx_pkg::*;
#(
  parameter int LOCK_TIMEOUT = LOCK_CYCLES,
  parameter int FIFO_DEPTH = 4,
  parameter int MIN_PERIOD = MIN_PERIOD_CYC,
  parameter int MAX_PERIOD = MAX_PERIOD_CYC
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // serial link pins, already differential-to-single
  input wire logic i_link_clock_in,
  input wire logic [LANES-1:0] i_serial_lane_in,
  // power control pin
  input wire logic i_sleep_n,
  // parallel side
  output logic [WORD_W-1:0] o_parallel_word_out,
  output logic o_parallel_strobe_out,
  output logic o_locked
);
  // pin synchronisers
  logic clk_s1_reg;
  logic clk_s2_reg;
  logic clk_s3_reg;
  logic [LANES-1:0] lane_s1_reg;
  logic [LANES-1:0] lane_s2_reg;
  logic sleep_s1_reg;
  logic sleep_s2_reg;

  // period tracker
  lock_state_t state_reg;
  lock_state_t state_next;
  logic [PERIOD_W-1:0] phase_reg;
  logic [PERIOD_W-1:0] period_reg;
  logic [2:0] stable_reg;
  logic [31:0] lock_timer_reg;
  logic armed_reg;
  logic link_edge;
  logic clear;
  logic [PERIOD_W-1:0] measured;
  logic period_ok;
  logic period_close;
  logic stalled;
  logic [PERIOD_W-1:0] slot_pos;

  // sampler to fifo to output stage
  logic [WORD_W-1:0] samp_word;
  logic samp_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [WORD_W-1:0] fifo_out_data;
  logic out_take;

  // output stage
  logic [WORD_W-1:0] word_out_reg;
  logic strobe_reg;
  logic busy_reg;
  logic [PERIOD_W-1:0] out_cnt_reg;
  logic [PERIOD_W-1:0] out_period_reg;
  logic out_last;
  logic locked_reg;

  assign o_parallel_word_out = word_out_reg;
  assign o_parallel_strobe_out = strobe_reg;
  assign o_locked = locked_reg;

  // two flops per pin; stage three only remembers the clean level for edges
  // the flops carry no reset: they settle within two cycles of any pin change
  always_ff @(posedge i_clk) begin
    clk_s1_reg <= i_link_clock_in;
    clk_s2_reg <= clk_s1_reg;
    clk_s3_reg <= clk_s2_reg;
    lane_s1_reg <= i_serial_lane_in;
    lane_s2_reg <= lane_s1_reg;
    sleep_s1_reg <= i_sleep_n;
    sleep_s2_reg <= sleep_s1_reg;
  end

  // lanes and clock share one synchroniser depth, so their alignment holds
  assign link_edge = clk_s2_reg & ~clk_s3_reg;

  // sleep acts through the same clear as reset; three cycles, far under 1 us
  assign clear = i_reset | ~sleep_s2_reg;

  // cycles since the last rising edge of the link clock, saturating
  always_ff @(posedge i_clk) begin
    if (clear) begin
      phase_reg <= PERIOD_RESET;
    end else if (link_edge) begin
      phase_reg <= PERIOD_RESET;
    end else if (phase_reg != PERIOD_W'(MAX_PERIOD)) begin
      phase_reg <= phase_reg + 1'b1;
    end
  end

  // length of the period that ends at this edge
  assign measured = phase_reg + 1'b1;
  assign period_ok = (measured >= PERIOD_W'(MIN_PERIOD)) &
                     (phase_reg < PERIOD_W'(MAX_PERIOD));
  assign period_close = (measured == period_reg) |
                        (measured == period_reg + 1'b1) |
                        (measured + 1'b1 == period_reg);
  // a stopped link clock runs the phase into its ceiling
  assign stalled = (phase_reg == PERIOD_W'(MAX_PERIOD));

  // position within the link period as the sampler sees it: the synced edge
  // cycle is position 0, so below 14 cycles per period bit 0 is caught on the edge itself and bit 6
  // always lands before the next edge, never on it
  assign slot_pos = link_edge ? PERIOD_RESET : measured;

  // lock search: first edge, then a run of matching periods
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_SEARCH: begin
        if (link_edge) begin
          state_next = ST_TRACK;
        end
      end
      ST_TRACK: begin
        if (stalled) begin
          state_next = ST_SEARCH;
        end else if (link_edge & period_ok & period_close &
                     (stable_reg == 3'(STABLE_PERIODS - 1))) begin
          state_next = ST_LOCKED;
        end
      end
      ST_LOCKED: begin
        // losing the clock or a jump in its rate drops lock
        if (stalled | (link_edge & ~(period_ok & period_close))) begin
          state_next = ST_SEARCH;
        end
      end
      default: begin
        state_next = ST_SEARCH;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (clear) begin
      state_reg <= ST_SEARCH;
    end else if ((state_reg != ST_LOCKED) &&
                 (lock_timer_reg == 32'(LOCK_TIMEOUT - 1))) begin
      state_reg <= ST_SEARCH;
    end else begin
      state_reg <= state_next;
    end
  end

  // run of matching periods; a mismatch restarts the count
  always_ff @(posedge i_clk) begin
    if (clear) begin
      stable_reg <= '0;
    end else if (state_reg != ST_TRACK) begin
      stable_reg <= '0;
    end else if (link_edge) begin
      if (period_ok & period_close) begin
        stable_reg <= stable_reg + 1'b1;
      end else begin
        stable_reg <= '0;
      end
    end
  end

  // period estimate follows the link clock each edge
  always_ff @(posedge i_clk) begin
    if (clear) begin
      period_reg <= PERIOD_RESET;
    end else if (link_edge & ~stalled) begin
      period_reg <= measured;
    end
  end

  // lock watchdog: a search that overruns the lock budget starts over
  // the budget is the lock limit counted in system cycles
  always_ff @(posedge i_clk) begin
    if (clear) begin
      lock_timer_reg <= '0;
    end else if ((state_reg == ST_LOCKED) ||
                 (lock_timer_reg == 32'(LOCK_TIMEOUT - 1))) begin
      lock_timer_reg <= '0;
    end else begin
      lock_timer_reg <= lock_timer_reg + 1'b1;
    end
  end

  // sampling is armed only from the first edge after lock, so no half word
  always_ff @(posedge i_clk) begin
    if (clear) begin
      armed_reg <= 1'b0;
    end else if (state_reg != ST_LOCKED) begin
      armed_reg <= 1'b0;
    end else if (link_edge) begin
      armed_reg <= 1'b1;
    end
  end

  lane_sampler u_sampler (
    .i_clk(i_clk),
    .i_clear(clear),
    .i_edge(link_edge),
    .i_phase(slot_pos),
    .i_period(period_reg),
    .i_armed(armed_reg & (state_reg == ST_LOCKED)),
    .i_lanes(lane_s2_reg),
    .o_word(samp_word),
    .o_word_valid(samp_valid)
  );

  // jitter between link edges and the output pacing is absorbed here;
  // a word that finds the buffer full is refused, since the link cannot wait
  word_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_flush(clear | (state_reg != ST_LOCKED)),
    .i_in_valid(samp_valid & fifo_in_ready),
    .o_in_ready(fifo_in_ready),
    .i_in_data(samp_word),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(out_take),
    .o_out_data(fifo_out_data)
  );

  // output pacing: one word per measured link period
  // the period is latched at take, so a drifting link never cuts a pulse short
  assign out_last = busy_reg & (out_cnt_reg == out_period_reg - 1'b1);
  assign out_take = fifo_out_valid & (~busy_reg | out_last) &
                    (state_reg == ST_LOCKED);

  always_ff @(posedge i_clk) begin
    if (clear) begin
      busy_reg <= 1'b0;
      out_cnt_reg <= PERIOD_RESET;
      out_period_reg <= PERIOD_RESET;
    end else if (state_reg != ST_LOCKED) begin
      // a dropped lock abandons the word in flight
      busy_reg <= 1'b0;
      out_cnt_reg <= PERIOD_RESET;
    end else if (out_take) begin
      busy_reg <= 1'b1;
      out_cnt_reg <= PERIOD_RESET;
      out_period_reg <= period_reg;
    end else if (out_last) begin
      busy_reg <= 1'b0;
      out_cnt_reg <= PERIOD_RESET;
    end else if (busy_reg) begin
      out_cnt_reg <= out_cnt_reg + 1'b1;
    end
  end

  // data changes with the strobe rise and holds past its fall
  always_ff @(posedge i_clk) begin
    if (clear) begin
      word_out_reg <= WORD_RESET;
    end else if (state_reg != ST_LOCKED) begin
      word_out_reg <= WORD_RESET;
    end else if (out_take) begin
      word_out_reg <= fifo_out_data;
    end
  end

  // strobe high for (period >> 1) + 1 cycles, falls mid-period while data is steady
  // a lost lock drops the strobe together with the word, so the panel never
  // sees a high strobe over zeroed data
  always_ff @(posedge i_clk) begin
    if (clear) begin
      strobe_reg <= 1'b0;
    end else if (state_reg != ST_LOCKED) begin
      strobe_reg <= 1'b0;
    end else if (out_take) begin
      strobe_reg <= 1'b1;
    end else if (busy_reg && (out_cnt_reg == (out_period_reg >> 1))) begin
      strobe_reg <= 1'b0;
    end
  end

  // lock indication for the panel logic
  // one cycle behind the tracker, in step with the zeroing of the outputs
  always_ff @(posedge i_clk) begin
    if (clear) begin
      locked_reg <= 1'b0;
    end else begin
      locked_reg <= (state_reg == ST_LOCKED);
    end
  end
endmodule // serial_to_parallel_panel_receiver

// File: dv/panel_rx_chk.sv
module panel_rx_chk
  import panel_rx_pkg::*;
(
  // clock, reset and power pin
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_sleep_n,
  // parallel side
  input wire logic [WORD_W-1:0] o_parallel_word_out,
  input wire logic o_parallel_strobe_out,
  input wire logic o_locked
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  logic [7:0] awake_reg;
  logic quiet;

  // cycles awake since reset or sleep; lock needs four whole periods first
  always_ff @(posedge i_clk) begin
    if (i_reset || !i_sleep_n) begin
      awake_reg <= 8'h00;
    end else if (awake_reg != 8'hff) begin
      awake_reg <= awake_reg + 8'h01;
    end
  end

  // outputs at rest
  assign quiet = (o_parallel_word_out == WORD_RESET) && !o_parallel_strobe_out;

  // a strobe pulse and a full link period seen while lock holds
  sequence s_pulse;
    $rose(o_parallel_strobe_out) ##1 o_locked [*5];
  endsequence
  sequence s_period;
    $rose(o_parallel_strobe_out) ##1 o_locked [*8] ##1 o_locked;
  endsequence

  property p_sleep_entry;
    $fell(i_sleep_n) |-> ##3 quiet;
  endproperty
  property p_sleep_hold;
    !i_sleep_n [*5] |-> quiet && !o_locked;
  endproperty
  property p_unlocked_quiet;
    !o_locked |-> quiet;
  endproperty
  property p_wake_quiet;
    $rose(i_sleep_n) |-> quiet [*8];
  endproperty
  property p_word_at_strobe;
    $changed(o_parallel_word_out) && !quiet |-> $rose(o_parallel_strobe_out);
  endproperty
  // a clear in mid-pulse is legal, so sleep cancels the attempt
  property p_strobe_shape;
    disable iff (i_reset || !i_sleep_n)
    s_pulse |-> !o_parallel_strobe_out && $past(o_parallel_strobe_out, 2)
      && $past(o_parallel_strobe_out, 4);
  endproperty
  property p_strobe_period;
    disable iff (i_reset || !i_sleep_n)
    s_period |-> $past(o_parallel_strobe_out) && !$past(o_parallel_strobe_out, 2);
  endproperty
  property p_lock_delay;
    $rose(o_locked) |-> awake_reg >= 8'h20;
  endproperty

  a_sleep_entry: assert property (p_sleep_entry) else $error("outputs not low after sleep");
  a_sleep_hold: assert property (p_sleep_hold) else $error("output active in sleep");
  a_unlocked_quiet: assert property (p_unlocked_quiet) else $error("output before lock");
  a_wake_quiet: assert property (p_wake_quiet) else $error("output right after wake");
  a_word_at_strobe: assert property (p_word_at_strobe) else $error("word moved off strobe");
  a_strobe_shape: assert property (p_strobe_shape) else $error("strobe pulse width wrong");
  a_strobe_period: assert property (p_strobe_period) else $error("strobe period wrong");
  a_lock_delay: assert property (p_lock_delay) else $error("lock came too soon");
endmodule // panel_rx_chk

bind serial_to_parallel_panel_receiver panel_rx_chk u_chk (
  .i_clk(i_clk),
  .i_reset(i_reset),
  .i_sleep_n(i_sleep_n),
  .o_parallel_word_out(o_parallel_word_out),
  .o_parallel_strobe_out(o_parallel_strobe_out),
  .o_locked(o_locked)
);

// File: dv/link_tx_model.sv
module link_tx_model
  import panel_rx_pkg::*;
(
  // what to send and how fast
  input wire logic i_run,
  input wire logic [WORD_W-1:0] i_word,
  input wire logic [15:0] i_period_ns,
  // link pins
  output logic o_link_clock,
  output logic [LANES-1:0] o_lanes
);
  timeunit 1ns;
  timeprecision 1ps;

  // one word per period, seven slots; clock high for four slots
  initial begin
    realtime slot;
    logic [WORD_W-1:0] w;
    o_link_clock = 1'b0;
    o_lanes = '0;
    forever begin
      if (!i_run) begin
        o_link_clock = 1'b0;
        o_lanes = ~o_lanes; // idle lanes hold no stale value
        #10;
      end else begin
        slot = i_period_ns / 7.0;
        w = i_word;
        for (int k = 0; k < BITS_PER_LANE; k++) begin
          o_link_clock = (k < 4);
          for (int l = 0; l < LANES; l++) begin
            o_lanes[l] = w[l*BITS_PER_LANE+k];
          end
          #(slot);
        end
      end
    end
  end
endmodule // link_tx_model

// File: dv/tb.sv
module tb
  import panel_rx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_sleep_n = 1'b1;
  logic link_run = 1'b0;
  logic [WORD_W-1:0] tx_word = 28'h5a3c7e1;
  logic [15:0] tx_period = 16'h00c8;
  logic link_clk;
  logic [LANES-1:0] lanes;
  logic [WORD_W-1:0] word;
  logic strobe;
  logic locked;
  int n_fail = 0;
  int compares = 0;
  logic [WORD_W-1:0] pats [4] = '{28'h5a3c7e1, 28'ha5c381e, 28'hc00000f, 28'hfffffff};

  always #12.5 i_clk = ~i_clk;

  link_tx_model u_tx (
    .i_run(link_run),
    .i_word(tx_word),
    .i_period_ns(tx_period),
    .o_link_clock(link_clk),
    .o_lanes(lanes)
  );

  serial_to_parallel_panel_receiver u_dut (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_link_clock_in(link_clk),
    .i_serial_lane_in(lanes),
    .i_sleep_n(i_sleep_n),
    .o_parallel_word_out(word),
    .o_parallel_strobe_out(strobe),
    .o_locked(locked)
  );

  task automatic chk_word(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp, input string what);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s is %b", $time, what, got);
    end
  endtask

  task automatic wait_lock();
    for (int i = 0; i < 400 && locked !== 1'b1; i++) @(negedge i_clk);
    chk_flag(locked, 1'b1, "lock");
  endtask

  // downstream capture happens where the strobe falls
  task automatic grab(output logic [WORD_W-1:0] w);
    logic prev;
    prev = strobe;
    w = 'x;
    for (int i = 0; i < 100; i++) begin
      @(negedge i_clk);
      if (prev === 1'b1 && strobe === 1'b0) begin
        w = word;
        return;
      end
      prev = strobe;
    end
  endtask

  // a few words settle between pattern changes, so skip stale ones
  task automatic grab_check();
    logic [WORD_W-1:0] w;
    repeat (4) grab(w);
    chk_word(w, tx_word);
  endtask

  task automatic t_stream();
    foreach (pats[i]) begin
      tx_word = pats[i];
      grab_check();
    end
    $display("test stream done");
  endtask

  task automatic t_sleep();
    int n;
    n = 0;
    i_sleep_n = 1'b0;
    while (n < 60 && !(word === WORD_RESET && strobe === 1'b0 && locked === 1'b0)) begin
      @(negedge i_clk);
      n++;
    end
    chk_flag(n <= 40, 1'b1, "sleep entry");
    repeat (20) @(negedge i_clk);
    chk_word(word, WORD_RESET);
    i_sleep_n = 1'b1;
    repeat (30) begin
      @(negedge i_clk);
      chk_word(word, WORD_RESET);
    end
    wait_lock();
    grab_check();
    $display("test sleep done");
  endtask

  // a period under seven cycles must never be locked to
  task automatic t_bad_period();
    tx_period = 16'h0096;
    repeat (200) @(negedge i_clk);
    chk_flag(locked, 1'b0, "lock at fast link");
    chk_word(word, WORD_RESET);
    chk_flag(strobe, 1'b0, "strobe at fast link");
    tx_period = 16'h00c8;
    wait_lock();
    grab_check();
    $display("test bad period done");
  endtask

  task automatic complete_run();
    $display("compares %0d failures %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // main sequence; inputs move on the falling edge
  initial begin
    repeat (3) @(negedge i_clk);
    i_reset = 1'b0;
    link_run = 1'b1;
    wait_lock();
    t_stream();
    t_sleep();
    t_bad_period();
    complete_run();
  end

  // whole run is well under 1000 cycles, so this only trips on a hang
  initial begin
    #300us;
    n_fail++;
    complete_run();
  end
endmodule // tb
